// [hdl/gpio_cde_consts.svh]
// Functional notes
// - Pullup acts only while pin is input; an enabled output buffer (direction, timer or SPI owner) forces it off.
// - Pullup bit 1 connects pullup, 0 disconnects; port D enables reset to 0.
// - Port D pullup register has eight independent bits at its own address.
// - Port C pullup register has seven independently writable bits.
// - Port D data latch is eight bits and untouched by reset.
// - Direction 1 enables output buffer, 0 disables; reset clears port D direction.
// - Latches accept writes in any direction; input pins stay unaffected.
// - Port D bits 7..4 go to timer channels when edge/level select claims them.
// - Port D bits 3..1 serve SPI while SPI enabled, else general purpose.
// - Port D bit 0 is SPI slave select only when enabled and not master.
// - SPI-owned port D pins ignore direction for drive, not for reads.
// - Port E bit 1 serial receive, bit 0 serial transmit while serial enabled.
// - Serial-owned port E pins ignore direction for drive, not for reads.
// - Reset clears both port E direction bits.
`ifndef GPIO_CDE_CONSTS_SVH
`define GPIO_CDE_CONSTS_SVH
// ****************************************
// Register map
// ****************************************
`define ADDR_PD_LATCH 8'h03
`define ADDR_PE_LATCH 8'h08
`define ADDR_PD_PULLUP 8'h0F
`define ADDR_PC_PULLUP 8'h0E
`define ADDR_PD_DIR 8'h07
`define ADDR_PE_DIR 8'h0C
`define ADDR_ALT_CTRL 8'h10
// ****************************************
// Reset values and field positions
// ****************************************
`define PD_PULLUP_RESET 8'h00
`define PC_PULLUP_RESET 7'h00
`define PD_DIR_RESET 8'h00
`define PE_DIR_RESET 2'h0
`define ALT_CTRL_RESET 4'h0
`define ALT_SPI_EN 0
`define ALT_SPI_MSTR 1
`define ALT_SCI_EN 2
`define SYNC_INIT 1'h0
`endif

// [hdl/gpio_cde_pkg.sv]
package gpio_cde_pkg;
  // Bus request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  // Timer channel claim per pin
  typedef struct packed {
    logic [3:0] claim;
    logic [3:0] drive;
    logic [3:0] out_en;
  } timer_pins_t;
  // Spi side signals
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } spi_drive_t;
endpackage

// [hdl/pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cde_consts.svh"
// Two-stage level synchroniser, one per bit
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  // First stage read only by second stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q <= {WIDTH{`SYNC_INIT}};
      sync_q <= {WIDTH{`SYNC_INIT}};
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end
  assign sync_o = sync_q;
endmodule
`default_nettype wire

// [hdl/shared_io_ports_cde.sv]
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cde_consts.svh"
module shared_io_ports_cde (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire gpio_cde_pkg::bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // Port C pullup control (pc_direction comes from outside)
  input wire logic [6:0] pc_direction_i,
  output logic [6:0] pc_pullup_on_o,
  // Port D pins
  input wire logic [7:0] pd_pin_i,
  output logic [7:0] pd_pin_o,
  output logic [7:0] pd_pin_oe_n_o,
  output logic [7:0] pd_pullup_on_o,
  // Port E pins
  input wire logic [1:0] pe_pin_i,
  output logic [1:0] pe_pin_o,
  output logic [1:0] pe_pin_oe_n_o,
  // Timer channel claims on port D 7..4
  input wire gpio_cde_pkg::timer_pins_t timer_i,
  output logic [3:0] timer_chan_in_o,
  // SPI
  input wire gpio_cde_pkg::spi_drive_t spi_i,
  output logic spi_enable_bit_o,
  output logic spi_master_sel_o,
  output logic spi_sck_in_o,
  output logic spi_mosi_in_o,
  output logic spi_miso_in_o,
  output logic spi_ss_n_o,
  // Serial interface
  input wire logic sci_txd_i,
  output logic serial_if_enable_o,
  output logic sci_rxd_o
);
  import gpio_cde_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] pd_latch_q;
  logic [1:0] pe_latch_q;
  logic [7:0] pd_direction_q;
  logic [1:0] pe_direction_q;
  logic [7:0] pd_pullup_en_q;
  logic [6:0] pc_pullup_en_q;
  logic [3:0] alt_ctrl_q;
  logic [7:0] rdata_q;
  logic [7:0] pd_sync;
  logic [1:0] pe_sync;
  logic [7:0] pd_drive;
  logic [7:0] pd_oe;
  logic [1:0] pe_drive;
  logic [1:0] pe_oe;
  logic spi_on;
  logic ss_used;
  logic sci_on;

  // Write decode shared by all registers
  function automatic logic hit(input bus_req_t b, input logic [7:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // Mixes latch and pin per direction bit
  function automatic logic [7:0] mix(input logic [7:0] dir, input logic [7:0] lat,
                                     input logic [7:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction

  // ****************************************
  // Data latches
  // ****************************************
  // No reset term: latch content survives reset
  always_ff @(posedge clk_i) begin
    if (hit(bus_i, `ADDR_PD_LATCH)) begin
      pd_latch_q <= bus_i.wdata;
    end
    if (hit(bus_i, `ADDR_PE_LATCH)) begin
      pe_latch_q <= bus_i.wdata[1:0];
    end
  end

  // Direction registers
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pd_direction_q <= `PD_DIR_RESET;
      pe_direction_q <= `PE_DIR_RESET;
    end else begin
      if (hit(bus_i, `ADDR_PD_DIR)) begin
        pd_direction_q <= bus_i.wdata;
      end
      if (hit(bus_i, `ADDR_PE_DIR)) begin
        pe_direction_q <= bus_i.wdata[1:0];
      end
    end
  end

  // Pullup enables, one independent bit per pin
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pd_pullup_en_q <= `PD_PULLUP_RESET;
      pc_pullup_en_q <= `PC_PULLUP_RESET;
    end else begin
      if (hit(bus_i, `ADDR_PD_PULLUP)) begin
        pd_pullup_en_q <= bus_i.wdata;
      end
      if (hit(bus_i, `ADDR_PC_PULLUP)) begin
        pc_pullup_en_q <= bus_i.wdata[6:0];
      end
    end
  end

  // Stand-in for the SPI and serial enables, kept local to the ports
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      alt_ctrl_q <= `ALT_CTRL_RESET;
    end else if (hit(bus_i, `ADDR_ALT_CTRL)) begin
      alt_ctrl_q <= bus_i.wdata[3:0];
    end
  end

  assign spi_on = alt_ctrl_q[`ALT_SPI_EN];
  assign sci_on = alt_ctrl_q[`ALT_SCI_EN];
  assign ss_used = spi_on && !alt_ctrl_q[`ALT_SPI_MSTR];
  assign spi_enable_bit_o = spi_on;
  assign spi_master_sel_o = alt_ctrl_q[`ALT_SPI_MSTR];
  assign serial_if_enable_o = sci_on;

  // ****************************************
  // Pin input synchronisers
  // ****************************************
  pin_sync #(.WIDTH(8)) u_pd_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(pd_pin_i),
    .sync_o(pd_sync)
  );
  pin_sync #(.WIDTH(2)) u_pe_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i(pe_pin_i),
    .sync_o(pe_sync)
  );

  // ****************************************
  // Pin ownership and drive
  // ****************************************
  // Timer channels on bits 7..4
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_tim
      always_comb begin
        if (timer_i.claim[g]) begin
          pd_drive[g+4] = timer_i.drive[g];
          pd_oe[g+4] = timer_i.out_en[g];
        end else begin
          pd_drive[g+4] = pd_latch_q[g+4];
          pd_oe[g+4] = pd_direction_q[g+4];
        end
      end
    end
  endgenerate

  // SPI pins bits 3..0; direction bits ignored while owned
  always_comb begin
    pd_drive[3:0] = pd_latch_q[3:0];
    pd_oe[3:0] = pd_direction_q[3:0];
    if (spi_on) begin
      pd_drive[3] = spi_i.sck_o;
      pd_oe[3] = spi_i.sck_oe;
      pd_drive[2] = spi_i.mosi_o;
      pd_oe[2] = spi_i.mosi_oe;
      pd_drive[1] = spi_i.miso_o;
      pd_oe[1] = spi_i.miso_oe;
      // Slave select is input only; in master mode bit 0 stays general
      if (ss_used) begin
        pd_drive[0] = 1'b0;
        pd_oe[0] = 1'b0;
      end
    end
  end

  // Serial pins on port E
  always_comb begin
    pe_drive = pe_latch_q;
    pe_oe = pe_direction_q;
    if (sci_on) begin
      pe_drive[0] = sci_txd_i;
      pe_oe[0] = 1'b1;
      pe_drive[1] = 1'b0;
      pe_oe[1] = 1'b0;
    end
  end

  assign pd_pin_o = pd_drive;
  assign pd_pin_oe_n_o = ~pd_oe;
  assign pe_pin_o = pe_drive;
  assign pe_pin_oe_n_o = ~pe_oe;

  // Pullups only on pins not driven; follows real buffer state
  assign pd_pullup_on_o = pd_pullup_en_q & ~pd_oe;
  assign pc_pullup_on_o = pc_pullup_en_q & ~pc_direction_i;

  // Peripheral inputs use synchronised pin levels
  assign timer_chan_in_o = pd_sync[7:4];
  assign spi_sck_in_o = pd_sync[3];
  assign spi_mosi_in_o = pd_sync[2];
  assign spi_miso_in_o = pd_sync[1];
  assign spi_ss_n_o = ss_used ? pd_sync[0] : 1'b1;
  assign sci_rxd_o = sci_on ? pe_sync[1] : 1'b1;

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rdata_q <= 8'h00;
    end else if (bus_i.rd) begin
      case (bus_i.addr)
        `ADDR_PD_LATCH: rdata_q <= mix(pd_direction_q, pd_latch_q, pd_sync);
        `ADDR_PE_LATCH: rdata_q <= {6'h00, (pe_direction_q & pe_latch_q) |
                                           (~pe_direction_q & pe_sync)};
        `ADDR_PD_DIR: rdata_q <= pd_direction_q;
        `ADDR_PE_DIR: rdata_q <= {6'h00, pe_direction_q};
        `ADDR_PD_PULLUP: rdata_q <= pd_pullup_en_q;
        `ADDR_PC_PULLUP: rdata_q <= {1'b0, pc_pullup_en_q};
        `ADDR_ALT_CTRL: rdata_q <= {4'h0, alt_ctrl_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign rdata_o = rdata_q;
endmodule
`default_nettype wire

// [test/io_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module io_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire gpio_cde_pkg::bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] pd_pin_i,
  input wire logic [7:0] pd_pin_oe_n_o,
  input wire logic [7:0] pd_pullup_on_o,
  input wire logic [1:0] pe_pin_o,
  input wire logic [1:0] pe_pin_oe_n_o,
  input wire gpio_cde_pkg::timer_pins_t timer_i,
  input wire logic [3:0] timer_chan_in_o,
  input wire logic spi_enable_bit_o,
  input wire logic spi_master_sel_o,
  input wire logic spi_ss_n_o,
  input wire logic serial_if_enable_o,
  input wire logic sci_txd_i,
  input wire logic sci_rxd_o
);
  import gpio_cde_pkg::*;
  // ****
  // Checks
  // ****
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_no_read;
    !bus_i.rd;
  endsequence
  a_read_idle_zero: assert property (s_no_read |=> rdata_o == 8'h00)
    else $error("read data not zero");
  a_reset_all_in: assert property (
    $fell(reset_i) && timer_i.claim == 4'h0 |->
    pd_pin_oe_n_o == 8'hFF && pe_pin_oe_n_o == 2'h3)
    else $error("pins driven after reset");
  a_pullup_when_in: assert property (
    (pd_pullup_on_o & ~pd_pin_oe_n_o) == 8'h00)
    else $error("pullup on a driven pin");
  // Two flops: skip the edges whose history reaches into reset
  a_sync_two_flop: assert property (
    !$past(reset_i) && !$past(reset_i, 2) |->
    {timer_chan_in_o, 4'h0} == ($past(pd_pin_i, 2) & 8'hF0))
    else $error("pin sync latency wrong");
  a_ss_idle_high: assert property (
    !(spi_enable_bit_o && !spi_master_sel_o) |-> spi_ss_n_o)
    else $error("slave select not idle");
  a_sci_tx_drive: assert property (
    serial_if_enable_o |-> pe_pin_oe_n_o == 2'b10 && pe_pin_o[0] == sci_txd_i)
    else $error("serial pins wrong");
  a_rxd_idle_high: assert property (!serial_if_enable_o |-> sci_rxd_o)
    else $error("receive not idle");
  a_timer_claim_oe: assert property (
    timer_i.claim[0] |-> pd_pin_oe_n_o[4] == !timer_i.out_en[0])
    else $error("timer claim ignored");
endmodule
bind shared_io_ports_cde io_chk i_chk (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
  .rdata_o(rdata_o), .pd_pin_i(pd_pin_i), .pd_pin_oe_n_o(pd_pin_oe_n_o),
  .pd_pullup_on_o(pd_pullup_on_o), .pe_pin_o(pe_pin_o), .pe_pin_oe_n_o(pe_pin_oe_n_o),
  .timer_i(timer_i), .timer_chan_in_o(timer_chan_in_o), .spi_enable_bit_o(spi_enable_bit_o),
  .spi_master_sel_o(spi_master_sel_o), .spi_ss_n_o(spi_ss_n_o),
  .serial_if_enable_o(serial_if_enable_o), .sci_txd_i(sci_txd_i), .sci_rxd_o(sci_rxd_o));
`default_nettype wire

// [test/pin_board.sv]
`timescale 1ns/1ps
`default_nettype none
module pin_board #(
  parameter int W = 8
) (
  input wire logic clk_i,
  input wire logic [W-1:0] drv_i,
  input wire logic [W-1:0] oe_n_i,
  input wire logic [W-1:0] pull_i,
  input wire logic [W-1:0] ext_v_i,
  input wire logic [W-1:0] ext_en_i,
  output logic [W-1:0] pin_o
);
  logic [W-1:0] last_q;
  // Floating lines flip each cycle so no stale level reads as valid
  always_ff @(posedge clk_i) begin
    last_q <= pin_o;
  end
  // Own drive, then board, then pullup (already gated by output enable)
  always_comb begin
    for (int b = 0; b < W; b++) begin
      if (!oe_n_i[b]) pin_o[b] = drv_i[b];
      else if (ext_en_i[b]) pin_o[b] = ext_v_i[b];
      else if (pull_i[b]) pin_o[b] = 1'b1;
      else pin_o[b] = ~last_q[b];
    end
  end
endmodule
`default_nettype wire

// [test/tb_shared_io_ports_cde.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cde_consts.svh"
module tb_shared_io_ports_cde;
  import gpio_cde_pkg::*;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  bus_req_t bus_i = '0;
  timer_pins_t timer_i = '0;
  spi_drive_t spi_i = '0;
  logic [6:0] pc_dir = 7'h00, pc_pu;
  logic [7:0] rdata, pd_in, pd_o, pd_oe_n, pd_pu, pd_ev = 8'h96, pd_ee = 8'hFF, v;
  logic [1:0] pe_in, pe_o, pe_oe_n, pe_ev = 2'b00, pe_ee = 2'b11;
  logic [3:0] tmr_in;
  logic txd = 1'b1, ss_n, rxd, sck_in, mosi_in, miso_in;
  int num_errors = 0, checked = 0;
  row_t rows[6] = '{'{`ADDR_PD_PULLUP, 8'hA5, 8'hA5}, '{`ADDR_PC_PULLUP, 8'hFF, 8'h7F},
    '{`ADDR_PD_DIR, 8'h3C, 8'h3C}, '{`ADDR_PE_DIR, 8'hFF, 8'h03},
    '{`ADDR_ALT_CTRL, 8'h02, 8'h02}, '{8'h20, 8'h5A, 8'h00}};
  shared_io_ports_cde i_dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(rdata),
    .pc_direction_i(pc_dir), .pc_pullup_on_o(pc_pu), .pd_pin_i(pd_in), .pd_pin_o(pd_o),
    .pd_pin_oe_n_o(pd_oe_n), .pd_pullup_on_o(pd_pu), .pe_pin_i(pe_in), .pe_pin_o(pe_o),
    .pe_pin_oe_n_o(pe_oe_n), .timer_i(timer_i), .timer_chan_in_o(tmr_in), .spi_i(spi_i),
    .spi_enable_bit_o(), .spi_master_sel_o(), .spi_sck_in_o(sck_in), .spi_mosi_in_o(mosi_in),
    .spi_miso_in_o(miso_in), .spi_ss_n_o(ss_n), .sci_txd_i(txd), .serial_if_enable_o(),
    .sci_rxd_o(rxd));
  pin_board #(.W(8)) i_pd (.clk_i(clk_i), .drv_i(pd_o), .oe_n_i(pd_oe_n), .pull_i(pd_pu),
    .ext_v_i(pd_ev), .ext_en_i(pd_ee), .pin_o(pd_in));
  pin_board #(.W(2)) i_pe (.clk_i(clk_i), .drv_i(pe_o), .oe_n_i(pe_oe_n), .pull_i(2'b00),
    .ext_v_i(pe_ev), .ext_en_i(pe_ee), .pin_o(pe_in));
  // ****
  // Tasks
  // ****
  always #2.5 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask
  // Data is valid only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 chk(what, rdata, e);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Hang guard, far beyond the fewer than one hundred cycles the tests need
  initial begin
    #10000;
    num_errors++;
    summarize();
  end
  // ****
  // Sequence
  // ****
  initial begin
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`ADDR_PD_DIR, 8'h00, "pd dir reset");
    rd(`ADDR_PE_DIR, 8'h00, "pe dir reset");
    rd(`ADDR_PD_PULLUP, 8'h00, "pd pullup reset");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "register");
    end
    pc_dir <= 7'h0F;
    @(posedge clk_i);
    #1 chk("pc pullup", {1'b0, pc_pu}, 8'h70);
    $display("registers done");
    wr(`ADDR_PD_PULLUP, 8'h00);
    wr(`ADDR_PD_DIR, 8'h00);
    // Latch first, then direction, so no stale level reaches the pins
    wr(`ADDR_PD_LATCH, 8'h5A);
    rd(`ADDR_PD_LATCH, 8'h96, "pd input read");
    wr(`ADDR_PD_DIR, 8'hF0);
    // Registers settle after the launching edge
    #1 chk("pd drive", {pd_oe_n[3:0], pd_o[7:4]}, 8'hF5);
    rd(`ADDR_PD_LATCH, 8'h56, "pd mixed read");
    pd_ee <= 8'h00;
    wr(`ADDR_PD_PULLUP, 8'hFF);
    #1 chk("pd pullup on", pd_pu, 8'h0F);
    // One more edge so both sync stages hold the pulled level
    @(posedge clk_i);
    rd(`ADDR_PD_LATCH, 8'h5F, "pd pulled read");
    $display("port d done");
    pd_ev <= 8'h00;
    pd_ee <= 8'h01;
    spi_i.sck_oe <= 1'b1;
    wr(`ADDR_PD_DIR, 8'h08);
    wr(`ADDR_ALT_CTRL, 8'h01);
    #1 chk("spi drive", {4'h0, pd_oe_n[3:0]}, 8'h07);
    rd(`ADDR_PD_LATCH, 8'hFE, "spi read");
    chk("spi inputs", {5'h0, sck_in, mosi_in, miso_in}, 8'h03);
    chk("slave select", {7'h0, ss_n}, 8'h00);
    wr(`ADDR_ALT_CTRL, 8'h00);
    $display("spi done");
    pe_ee <= 2'b10;
    wr(`ADDR_PE_LATCH, 8'h00);
    wr(`ADDR_PE_DIR, 8'h02);
    wr(`ADDR_ALT_CTRL, 8'h04);
    #1 chk("serial drive", {6'h0, pe_oe_n}, 8'h02);
    // Transmit level needs two edges through the synchroniser
    @(posedge clk_i);
    rd(`ADDR_PE_LATCH, 8'h01, "pe read");
    chk("serial rx", {7'h0, rxd}, 8'h00);
    wr(`ADDR_ALT_CTRL, 8'h00);
    timer_i <= '{claim: 4'h1, drive: 4'h0, out_en: 4'h1};
    @(posedge clk_i);
    #1 chk("timer pin", {6'h0, pd_oe_n[4], pd_o[4]}, 8'h00);
    timer_i <= '0;
    $display("alternate done");
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`ADDR_PD_DIR, 8'h00, "pd dir rereset");
    wr(`ADDR_PD_DIR, 8'hFF);
    rd(`ADDR_PD_LATCH, 8'h5A, "latch kept");
    $display("reset done");
    summarize();
  end
endmodule
`default_nettype wire
